// *** rtl/dbm_regs.vh ***
// register map and field constants of the display bus mapper
// assumes a plain byte-addressed port of word-aligned registers and one 200 MHz clock
`ifndef DBM_REGS_VH
`define DBM_REGS_VH

`define DBM_ADDR_W 8
`define DBM_BUS_W 18
`define DBM_BUS_MIN 5'h08
`define DBM_BUS_MAX 5'h12
`define DBM_MAP_CNT 18
`define DBM_MAP_W 31
`define DBM_ACC_ADDR 8'h48
`define DBM_CTRL_ADDR 8'h4C
`define DBM_STAT_ADDR 8'h50
`define DBM_BYTE_OFFSET_CYCLE0_LSB 0
`define DBM_BYTE_OFFSET_CYCLE1_LSB 5
`define DBM_BYTE_OFFSET_CYCLE2_LSB 10
`define DBM_MASK_LSB 15
`define DBM_CODE_MASKED 2'h3
`define DBM_CTRL_WIDTH_LSB 0
`define DBM_CTRL_SYNC_BIT 5
`define DBM_CTRL_SER1_BIT 6
`define DBM_CTRL_SER2_BIT 7
`define DBM_CTRL_DIV_LSB 8
`define DBM_MAP_RST 31'h0000_0000
`define DBM_ACC_RST 12'h000
`define DBM_CTRL_RST 16'h0010

`endif

// *** rtl/dbm_byte_place.v ***
// places one byte of the internal word onto the panel bus lines
// for one transfer cycle; pure combinational, fed by the mapper
`default_nettype none
`include "dbm_regs.vh"

module dbm_byte_place (
  input wire [7:0] byte_i,
  input wire [30:0] map_i,
  input wire [1:0] cyc_i,
  output reg [17:0] lines_o
);

  always @* begin : place
    integer j;
    reg [3:0] rank;
    reg [1:0] code;
    reg [4:0] offs;
    reg [5:0] pos;
    lines_o = 18'h0_0000;
    j = 0;
    offs = 5'h00;
    rank = 4'h0;
    code = 2'h0;
    pos = 6'h00;
    case (cyc_i)
      2'h0: offs = map_i[`DBM_BYTE_OFFSET_CYCLE0_LSB +: 5];
      2'h1: offs = map_i[`DBM_BYTE_OFFSET_CYCLE1_LSB +: 5];
      default: offs = map_i[`DBM_BYTE_OFFSET_CYCLE2_LSB +: 5];
    endcase
    for (j = 7; j >= 0; j = j - 1) begin
      code = map_i[`DBM_MASK_LSB + 2 * j +: 2];
      if (code != `DBM_CODE_MASKED) begin
        // rank counts every unmasked higher bit, whatever its cycle
        pos = {1'b0, offs} - {2'b00, rank};
        if (code == cyc_i && byte_i[j] && {1'b0, offs} >= {2'b00, rank} &&
            pos < 6'h12) begin
          lines_o[pos[4:0]] = 1'b1;
        end
        rank = rank + 4'h1;
      end
    end
  end

endmodule
`default_nettype wire

// *** rtl/dbm_mapper.v ***
// display bus mapper: arbitrates three display word sources,
// serialises each 24-bit word onto the shared parallel panel bus, or for displays 1 and 2 in serial mode hands it to the serial engine
// assumes sources, sync controller and serial engine share sys_clk_i
`default_nettype none
`include "dbm_regs.vh"

module dbm_mapper (
  input wire sys_clk_i,
  input wire rst_i,
  input wire [7:0] reg_addr_i,
  input wire [31:0] reg_wdata_i,
  input wire reg_wr_i,
  input wire reg_rd_i,
  output reg [31:0] reg_rdata_o,
  input wire [2:0] src_valid_i,
  input wire [71:0] src_word_i,
  input wire [2:0] src_cmd_i,
  input wire [2:0] src_narrow_i,
  output reg [2:0] src_ready_o,
  input wire sync_porch_i,
  output reg [17:0] panel_data_bus_o,
  output reg reg_select_o,
  output reg [2:0] panel_disp_o,
  output reg panel_xfer_o,
  output reg [23:0] ser_word_o,
  output reg ser_reg_select_o,
  output reg [1:0] ser_disp_o,
  output reg ser_valid_o,
  input wire ser_ready_i
);

  localparam ST_IDLE = 2'b01;
  localparam ST_XFER = 2'b10;

  reg [30:0] map_q [0:17];
  reg [11:0] acc_q;
  reg [15:0] ctrl_q;
  reg [15:0] words_q;
  reg [1:0] st_q;
  reg [1:0] cyc_q;
  reg [23:0] cur_word_q;
  reg cur_cmd_q;
  reg [1:0] cur_disp_q;
  reg [7:0] div_q;
  reg [1:0] rr_q;
  reg ser_last_q;
  reg [2:0] rdy_ser_q;
  reg [26:0] fifo_q [0:1];
  reg wp_q;
  reg rp_q;
  reg [1:0] lvl_q;
  reg [1:0] lvl_d;
  reg [2:0] rdy_d;
  reg [2:0] rdy_ser_d;
  reg [23:0] in_word;
  reg [1:0] in_disp;
  reg in_cmd;
  reg [4:0] base;
  reg [1:0] cnt_sel;
  reg [4:0] width_eff;
  reg [31:0] rd_mux;
  reg ser_valid_d;
  integer i;

  wire [2:0] ser_mode;
  wire [23:0] ext_word [0:2];
  wire [17:0] byte_lines [0:2];
  wire [17:0] wmask;
  wire [2:0] par_take;
  wire [2:0] ser_take;
  wire push;
  wire pop;
  wire tick;
  wire allow;
  wire [2:0] par_req;
  wire [2:0] ser_req;

  // display 0 has no serial path
  assign ser_mode = {ctrl_q[`DBM_CTRL_SER2_BIT], ctrl_q[`DBM_CTRL_SER1_BIT], 1'b0};
  assign par_take = src_valid_i & src_ready_o & ~rdy_ser_q;
  assign ser_take = src_valid_i & src_ready_o & rdy_ser_q;
  assign push = |par_take;
  assign pop = (st_q == ST_IDLE) && (lvl_q != 2'h0);
  assign tick = (div_q == 8'h00);
  // a sync panel owns the bus outside its porches
  assign allow = ~ctrl_q[`DBM_CTRL_SYNC_BIT] | sync_porch_i;
  assign par_req = src_valid_i & ~ser_mode;
  assign ser_req = src_valid_i & ser_mode;

  genvar g;
  generate
    for (g = 0; g < 3; g = g + 1) begin : gen_byte
      assign ext_word[g] = src_narrow_i[g] ?
        {8'h00, src_word_i[24 * g +: 16]} : src_word_i[24 * g +: 24];
      dbm_byte_place u_place (
        .byte_i(cur_word_q[8 * g +: 8]),
        .map_i(map_q[base + g[4:0]]),
        .cyc_i(cyc_q),
        .lines_o(byte_lines[g])
      );
    end
    for (g = 0; g < `DBM_BUS_W; g = g + 1) begin : gen_wmask
      assign wmask[g] = (g[4:0] < width_eff);
    end
  endgenerate

  always @* begin
    // map index = display * 6 + command * 3 + byte
    case (cur_disp_q)
      2'h1: base = 5'd6;
      2'h2: base = 5'd12;
      default: base = 5'd0;
    endcase
    if (cur_cmd_q) begin
      base = base + 5'd3;
    end
    cnt_sel = acc_q[{cur_disp_q, cur_cmd_q, 1'b0} +: 2];
    if (cnt_sel == 2'h3) begin
      cnt_sel = 2'h2;
    end
    width_eff = ctrl_q[`DBM_CTRL_WIDTH_LSB +: 5];
    if (width_eff < `DBM_BUS_MIN) begin
      width_eff = `DBM_BUS_MIN;
    end else if (width_eff > `DBM_BUS_MAX) begin
      width_eff = `DBM_BUS_MAX;
    end
  end

  always @* begin
    in_word = ext_word[0];
    in_disp = 2'h0;
    in_cmd = src_cmd_i[0];
    if (par_take[1]) begin
      in_word = ext_word[1];
      in_disp = 2'h1;
      in_cmd = src_cmd_i[1];
    end else if (par_take[2]) begin
      in_word = ext_word[2];
      in_disp = 2'h2;
      in_cmd = src_cmd_i[2];
    end
  end

  // round robin grant: parallel ready for next cycle only while the buffer has room, serial only while the serial word is free
  always @* begin : grant
    integer k;
    reg [1:0] idx;
    reg [2:0] sum;
    k = 0;
    idx = 2'h0;
    sum = 3'h0;
    lvl_d = lvl_q + {1'b0, push} - {1'b0, pop};
    ser_valid_d = (ser_valid_o & ~ser_ready_i) | (|ser_take);
    rdy_d = 3'h0;
    rdy_ser_d = 3'h0;
    if (lvl_d != 2'h2) begin
      for (k = 2; k >= 0; k = k - 1) begin
        // modulo three; a two-bit sum would wrap 2+2 onto display 0
        sum = {1'b0, rr_q} + {1'b0, k[1:0]};
        idx = (sum >= 3'h3) ? sum[1:0] - 2'h3 : sum[1:0];
        if (par_req[idx]) begin
          rdy_d = 3'h0;
          rdy_d[idx] = 1'b1;
        end
      end
    end
    if (!ser_valid_d) begin
      if (ser_req[2] && (ser_last_q || !ser_req[1])) begin
        rdy_d[2] = 1'b1;
        rdy_ser_d[2] = 1'b1;
      end else if (ser_req[1]) begin
        rdy_d[1] = 1'b1;
        rdy_ser_d[1] = 1'b1;
      end
    end
  end

  always @* begin
    rd_mux = 32'h0000_0000;
    if (reg_addr_i[1:0] == 2'h0 && reg_addr_i[7:2] < 6'd18) begin
      rd_mux = {1'b0, map_q[reg_addr_i[6:2]]};
    end else if (reg_addr_i == `DBM_ACC_ADDR) begin
      rd_mux = {20'h0_0000, acc_q};
    end else if (reg_addr_i == `DBM_CTRL_ADDR) begin
      rd_mux = {16'h0000, ctrl_q};
    end else if (reg_addr_i == `DBM_STAT_ADDR) begin
      rd_mux = {words_q, 9'h000, cur_cmd_q, cur_disp_q, ser_valid_o, lvl_q,
        st_q[1]};
    end
  end

  // register port: writes take effect at once, read data one cycle later
  always @(posedge sys_clk_i) begin
    if (rst_i) begin
      for (i = 0; i < `DBM_MAP_CNT; i = i + 1) begin
        map_q[i] <= `DBM_MAP_RST;
      end
      acc_q <= `DBM_ACC_RST;
      ctrl_q <= `DBM_CTRL_RST;
      reg_rdata_o <= 32'h0000_0000;
    end else begin
      reg_rdata_o <= reg_rd_i ? rd_mux : 32'h0000_0000;
      if (reg_wr_i) begin
        if (reg_addr_i[1:0] == 2'h0 && reg_addr_i[7:2] < 6'd18) begin
          map_q[reg_addr_i[6:2]] <= reg_wdata_i[30:0];
        end else if (reg_addr_i == `DBM_ACC_ADDR) begin
          acc_q <= reg_wdata_i[11:0];
        end else if (reg_addr_i == `DBM_CTRL_ADDR) begin
          ctrl_q <= reg_wdata_i[15:0];
        end
      end
    end
  end

  // two-entry buffer between grant and bus sequencer
  always @(posedge sys_clk_i) begin
    if (rst_i) begin
      fifo_q[0] <= 27'h000_0000;
      fifo_q[1] <= 27'h000_0000;
      wp_q <= 1'b0;
      rp_q <= 1'b0;
      lvl_q <= 2'h0;
      src_ready_o <= 3'h0;
      rdy_ser_q <= 3'h0;
      rr_q <= 2'h0;
    end else begin
      lvl_q <= lvl_d;
      src_ready_o <= rdy_d;
      rdy_ser_q <= rdy_ser_d;
      if (push) begin
        fifo_q[wp_q] <= {in_disp, in_cmd, in_word};
        wp_q <= ~wp_q;
        rr_q <= (in_disp == 2'h2) ? 2'h0 : in_disp + 2'h1;
      end
      if (pop) begin
        rp_q <= ~rp_q;
      end
    end
  end

  // serial path holds one word for the serial engine
  always @(posedge sys_clk_i) begin
    if (rst_i) begin
      ser_valid_o <= 1'b0;
      ser_word_o <= 24'h00_0000;
      ser_reg_select_o <= 1'b0;
      ser_disp_o <= 2'h0;
      ser_last_q <= 1'b0;
    end else begin
      ser_valid_o <= ser_valid_d;
      if (ser_take[1]) begin
        ser_word_o <= ext_word[1];
        ser_reg_select_o <= ~src_cmd_i[1];
        ser_disp_o <= 2'h1;
        ser_last_q <= 1'b1;
      end else if (ser_take[2]) begin
        ser_word_o <= ext_word[2];
        ser_reg_select_o <= ~src_cmd_i[2];
        ser_disp_o <= 2'h2;
        ser_last_q <= 1'b0;
      end
    end
  end

  // display clock enable
  always @(posedge sys_clk_i) begin
    if (rst_i) begin
      div_q <= 8'h00;
    end else if (tick) begin
      div_q <= ctrl_q[`DBM_CTRL_DIV_LSB +: 8];
    end else begin
      div_q <= div_q - 8'h01;
    end
  end

  // bus sequencer: one transfer per display clock while the bus is free
  always @(posedge sys_clk_i) begin
    if (rst_i) begin
      st_q <= ST_IDLE;
      cyc_q <= 2'h0;
      cur_word_q <= 24'h00_0000;
      cur_cmd_q <= 1'b0;
      cur_disp_q <= 2'h0;
      words_q <= 16'h0000;
      panel_data_bus_o <= 18'h0_0000;
      reg_select_o <= 1'b0;
      panel_disp_o <= 3'h0;
      panel_xfer_o <= 1'b0;
    end else begin
      panel_xfer_o <= 1'b0;
      case (st_q)
        ST_IDLE: begin
          if (pop) begin
            {cur_disp_q, cur_cmd_q, cur_word_q} <= fifo_q[rp_q];
            cyc_q <= 2'h0;
            st_q <= ST_XFER;
          end
        end
        ST_XFER: begin
          if (tick && allow) begin
            panel_data_bus_o <= (byte_lines[0] | byte_lines[1] | byte_lines[2]) &
              wmask;
            reg_select_o <= ~cur_cmd_q;
            panel_disp_o <= 3'h1 << cur_disp_q;
            panel_xfer_o <= 1'b1;
            if (cyc_q >= cnt_sel) begin
              st_q <= ST_IDLE;
              words_q <= words_q + 16'h0001;
            end else begin
              cyc_q <= cyc_q + 2'h1;
            end
          end
        end
        default: begin
          st_q <= ST_IDLE;
        end
      endcase
    end
  end

endmodule
`default_nettype wire

// *** dv/dbm_mapper_properties.sv ***
// port assertions of the display bus mapper
// assumes a bind into dbm_mapper, one clock, divider left at 0
`default_nettype none
module dbm_mapper_properties (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [31:0] reg_rdata_o,
  input wire logic [2:0] src_valid_i,
  input wire logic [2:0] src_ready_o,
  input wire logic sync_porch_i,
  input wire logic [17:0] panel_data_bus_o,
  input wire logic reg_select_o,
  input wire logic [2:0] panel_disp_o,
  input wire logic panel_xfer_o,
  input wire logic [23:0] ser_word_o,
  input wire logic [1:0] ser_disp_o,
  input wire logic ser_valid_o,
  input wire logic ser_ready_i
);
  logic sync_q;
  // shadow of the sync-panel bit, the gate needs it
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) sync_q <= 1'b0;
    else if (reg_wr_i && reg_addr_i == 8'h4C) sync_q <= reg_wdata_i[5];
  end
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);
  sequence s_take0;
    src_valid_i[0] && src_ready_o[0] && !sync_q;
  endsequence
  sequence s_first_xfer;
    ##[1:40] panel_xfer_o;
  endsequence
  a_reset_quiet: assert property (disable iff (1'b0)
    rst_i |=> !panel_xfer_o && src_ready_o == 3'h0 && !ser_valid_o)
    else $error("outputs active after reset");
  a_rdata_idle: assert property (!reg_rd_i |=> reg_rdata_o == 32'h0)
    else $error("read data outside read slot");
  a_take_sends: assert property (s_take0 |-> s_first_xfer)
    else $error("taken word never reached the bus");
  a_porch_gate: assert property (sync_q && !sync_porch_i [*2] |=> !panel_xfer_o)
    else $error("transfer outside sync porch");
  a_disp_onehot: assert property (panel_xfer_o |-> $onehot(panel_disp_o))
    else $error("transfer display not one-hot");
  a_bus_held: assert property (!panel_xfer_o |-> $stable(panel_data_bus_o)
    && $stable(reg_select_o) && $stable(panel_disp_o))
    else $error("bus changed between transfers");
  a_ser_hold: assert property (ser_valid_o && !ser_ready_i
    |=> ser_valid_o && $stable(ser_word_o) && $stable(ser_disp_o))
    else $error("serial word dropped while stalled");
  a_ser_disp: assert property (ser_valid_o |-> ser_disp_o inside {2'h1, 2'h2})
    else $error("serial word for wrong display");
endmodule
`default_nettype wire

// *** dv/dbm_panel_model.sv ***
// stand-in for the smart panel and serial engine: logs what arrives
// assumes the mapper clock; serial engine accepts one cycle in four
`default_nettype none
module dbm_panel_model (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic [17:0] panel_data_bus_i,
  input wire logic reg_select_i,
  input wire logic panel_xfer_i,
  input wire logic [2:0] panel_disp_i,
  input wire logic [23:0] ser_word_i,
  input wire logic ser_reg_select_i,
  input wire logic [1:0] ser_disp_i,
  input wire logic ser_valid_i,
  output logic ser_ready_o
);
  logic [21:0] got [$];
  logic [26:0] sgot [$];
  logic [1:0] stall_q;
  assign ser_ready_o = stall_q == 2'h3;
  always @(posedge sys_clk_i) begin
    stall_q <= rst_i ? 2'h0 : stall_q + 2'h1;
    if (!rst_i && panel_xfer_i)
      got.push_back({panel_disp_i, reg_select_i, panel_data_bus_i});
    if (!rst_i && ser_valid_i && ser_ready_o)
      sgot.push_back({ser_reg_select_i, ser_disp_i, ser_word_i});
  end
endmodule
`default_nettype wire

// *** dv/dbm_mapper_test.sv ***
// self-checking bench of the display bus mapper, random maps per word
// assumes reset values of dbm_mapper and a divider of 0
`default_nettype none
module dbm_mapper_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk_i = 0, rst_i = 1, reg_wr_i = 0, reg_rd_i = 0, sync_porch_i = 0;
  logic [7:0] reg_addr_i = 8'h00;
  logic [31:0] reg_wdata_i = 32'h0;
  logic [2:0] src_valid_i = 3'h0, src_cmd_i = 3'h0, src_narrow_i = 3'h0;
  logic [71:0] src_word_i = 72'h0;
  wire [31:0] reg_rdata_o;
  wire [2:0] src_ready_o, panel_disp_o;
  wire [17:0] panel_data_bus_o;
  wire [23:0] ser_word_o;
  wire [1:0] ser_disp_o;
  wire reg_select_o, panel_xfer_o, ser_reg_select_o, ser_valid_o, ser_ready_i;
  integer errors = 0, check_count = 0, seed = 70, cycles = 0;
  int n, wd, kt, cd;
  logic cmd, nar;
  logic [23:0] w, we;
  logic [30:0] map [3];
  // hand-made corner maps: two- and three-transfer layouts, byte2 first
  logic [30:0] corner [6] = '{31'h7AAA80A0, 31'h7AAA8160, 31'h782A822F,
    31'h7D551400, 31'h7AAA80A0, 31'h78000005};
  initial forever #2.5 sys_clk_i = ~sys_clk_i;
  dbm_mapper DUT (.sys_clk_i, .rst_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i,
    .reg_rdata_o, .src_valid_i, .src_word_i, .src_cmd_i, .src_narrow_i, .src_ready_o,
    .sync_porch_i, .panel_data_bus_o, .reg_select_o, .panel_disp_o, .panel_xfer_o,
    .ser_word_o, .ser_reg_select_o, .ser_disp_o, .ser_valid_o, .ser_ready_i);
  dbm_panel_model PANEL (.sys_clk_i, .rst_i, .panel_data_bus_i(panel_data_bus_o),
    .reg_select_i(reg_select_o), .panel_xfer_i(panel_xfer_o), .ser_word_i(ser_word_o),
    .panel_disp_i(panel_disp_o),
    .ser_reg_select_i(ser_reg_select_o), .ser_disp_i(ser_disp_o),
    .ser_valid_i(ser_valid_o), .ser_ready_o(ser_ready_i));
  task automatic test_done;
    if (errors == 0 && check_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count = check_count + 1;
    if (got !== exp) begin
      errors = errors + 1;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    @(posedge sys_clk_i);
    reg_wr_i <= 1'b0;
    // one idle edge, so a following write never re-drives the strobe in this step
    @(posedge sys_clk_i);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge sys_clk_i);
    reg_rd_i <= 1'b0;
    #1 chk(reg_rdata_o, e);
    @(posedge sys_clk_i);
  endtask
  task automatic send(input int d);
    src_valid_i[d] <= 1'b1;
    @(posedge sys_clk_i);
    while (src_ready_o[d] !== 1'b1) @(posedge sys_clk_i);
    src_valid_i[d] <= 1'b0;
  endtask
  // ranks count every unmasked bit, whatever cycle it goes in
  function automatic logic [17:0] exp_bus(input logic [23:0] e, input int c);
    logic [17:0] b;
    int ln;
    b = 18'h0;
    for (int k = 0; k < 3; k++) begin
      ln = map[k][5*c +: 5];
      for (int j = 7; j >= 0; j--) begin
        if (map[k][15+2*j +: 2] != 2'h3) begin
          // bytes landing on one line in one transfer merge by or
          if (map[k][15+2*j +: 2] == c && ln >= 0 && ln < wd)
            b[ln] = b[ln] | e[8*k+j];
          ln--;
        end
      end
    end
    return b;
  endfunction
  task automatic drain(input logic [23:0] e, input logic rs);
    for (int c = 0; c <= n; c++) begin
      wait (PANEL.got.size() > 0);
      chk(32'(PANEL.got.pop_front()), {10'h000, 3'h1, rs, exp_bus(e, c)});
    end
  endtask
  always @(posedge sys_clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 6000) begin
      errors = errors + 1;
      test_done;
    end
  end
  initial begin
    repeat (5) @(posedge sys_clk_i);
    rst_i <= 1'b0;
    @(posedge sys_clk_i);
    rd(8'h4C, 32'h10);
    rd(8'h7C, 32'h0);
    wr(8'h00, 32'hFFFFFFFF);
    rd(8'h00, 32'h7FFFFFFF);
    for (int t = 0; t < 30; t++) begin
      n = $unsigned($random(seed)) % 3;
      wd = 8 + $unsigned($random(seed)) % 11;
      cmd = $random(seed);
      nar = $random(seed);
      w = $random(seed);
      if (t < 2) begin
        n = t + 1;
        wd = 16;
      end
      for (int k = 0; k < 3; k++) begin
        for (int c = 0; c < 3; c++) map[k][5*c +: 5] = $unsigned($random(seed)) % 18;
        for (int j = 0; j < 8; j++) begin
          cd = $unsigned($random(seed)) % (n + 2);
          map[k][15+2*j +: 2] = (cd > n) ? 2'h3 : cd[1:0];
        end
        if (t < 2) map[k] = corner[3*t+k];
        wr(8'(4*(3*cmd+k)), {1'b0, map[k]});
      end
      wr(8'h48, 32'(n) << (2*cmd));
      rd(8'h48, 32'(n) << (2*cmd));
      wr(8'h4C, 32'(wd));
      src_cmd_i[0] <= cmd;
      src_narrow_i[0] <= nar;
      src_word_i[23:0] <= w;
      send(0);
      we = nar ? {8'h00, w[15:0]} : w;
      drain(we, !cmd);
      repeat (6) @(posedge sys_clk_i);
      chk(PANEL.got.size(), 0);
    end
    rd(8'h50, {16'h001E, 9'h000, cmd, 6'h00});
    // sync panel outside porch: words pile up, none may be lost
    wr(8'h4C, 32'(wd) | 32'h20);
    kt = 0;
    src_valid_i[0] <= 1'b1;
    repeat (30) begin
      src_word_i[23:0] <= w ^ 24'(kt);
      @(posedge sys_clk_i);
      if (src_ready_o[0] === 1'b1) kt++;
    end
    src_valid_i[0] <= 1'b0;
    chk(PANEL.got.size(), 0);
    chk(kt < 4, 1);
    sync_porch_i <= 1'b1;
    for (int i = 0; i < kt; i++) drain((w ^ 24'(i)) & {nar ? 8'h00 : 8'hFF, 16'hFFFF}, !cmd);
    wr(8'h4C, 32'(wd) | 32'h60);
    src_word_i <= {24'h0, ~w, w};
    src_cmd_i[1] <= cmd;
    fork
      send(0);
      send(1);
    join
    drain(we, !cmd);
    wait (PANEL.sgot.size() > 0);
    chk(32'(PANEL.sgot.pop_front()), {5'h0, !cmd, 2'h1, ~w});
    test_done;
  end
endmodule
bind dbm_mapper dbm_mapper_properties CHK (.sys_clk_i, .rst_i, .reg_addr_i, .reg_wdata_i,
  .reg_wr_i, .reg_rd_i, .reg_rdata_o, .src_valid_i, .src_ready_o, .sync_porch_i,
  .panel_data_bus_o, .reg_select_o, .panel_disp_o, .panel_xfer_o, .ser_word_o,
  .ser_disp_o, .ser_valid_o, .ser_ready_i);
`default_nettype wire
